// *** include/asdr_pkg.sv ***
// ----------------------------------------------------------------------
// Widths and register map
// ----------------------------------------------------------------------
package asdr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int ACC_W  = 14;
	localparam int TEMP_W = 8;
	localparam int QW_W   = 16;

	localparam logic [7:0] REG_ID       = 8'h00;
	localparam logic [7:0] REG_X_LO     = 8'h02;
	localparam logic [7:0] REG_X_HI     = 8'h03;
	localparam logic [7:0] REG_Y_LO     = 8'h04;
	localparam logic [7:0] REG_Y_HI     = 8'h05;
	localparam logic [7:0] REG_Z_LO     = 8'h06;
	localparam logic [7:0] REG_Z_HI     = 8'h07;
	localparam logic [7:0] REG_TEMP     = 8'h08;
	localparam logic [7:0] REG_STAT     = 8'h09;
	localparam logic [7:0] REG_STAT2    = 8'h0A;
	localparam logic [7:0] REG_CTRL     = 8'h0D;
	localparam logic [7:0] REG_SOFT_RST = 8'h10;

	// ------------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------------
	localparam int CTRL_SHORT      = 0;
	localparam int CTRL_SHADOW_DIS = 1;
	localparam int CTRL_NDI_EN     = 2;
	localparam int CTRL_RESET_INT  = 3;

	localparam int STAT_INT_LATCHED = 0;
	localparam int STAT_SIGN_LSB    = 1;
	localparam int STAT_FIRST_LSB   = 4;
	localparam int STAT_NVM_BUSY    = 7;

	localparam int STAT2_QUIET_VIOL = 0;
	localparam int STAT2_NEW_DATA   = 1;

	localparam int NEW_FLAG_POS = 0;
	localparam int LO_DATA_LSB  = 2;
	localparam int LO_ACC_BITS  = 6;
	localparam int SHORT_DROP   = 2;

	localparam logic [7:0] SOFT_RESET_CODE = 8'hB6;
	localparam logic [7:0] TEMP_RESET      = 8'h00;
	localparam logic [7:0] SHADOW_RESET    = 8'h00;

	localparam logic [1:0] CHAN_TEMP = 2'h0;
	localparam logic [1:0] CHAN_X    = 2'h1;
	localparam logic [1:0] CHAN_Z    = 2'h3;
	localparam logic [1:0] AXIS_NONE = 2'h3;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 8;
	localparam int UPDATE_PERIOD_NS = 400000;
	localparam int CONV_TIME_NS     = UPDATE_PERIOD_NS / 4;
	// Longest time, so rounded down
	localparam int CONV_CYCLES      = CONV_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		QW_IDLE = 2'h0,
		QW_OPEN = 2'h1,
		QW_SHUT = 2'h3
	} asdr_qw_t;

endpackage

// *** rtl/asdr_sync.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------
module asdr_sync #(
	parameter int W = 1
) (
	input  wire logic         CLK,
	input  wire logic         ARST_N,
	input  wire logic         CE,
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} asdr_sync_t;

	asdr_sync_t st;
	asdr_sync_t next_st;

	always_comb
	begin
		next_st    = st;
		next_st.s1 = D;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		// Both pins idle high; resetting low would fake an edge
		if (!ARST_N)
			st <= '1;
		else if (CE)
			st <= next_st;
	end

	assign Q = st.s2;
endmodule

// *** rtl/asdr_readout.sv ***
`timescale 1ns/100ps
//
// Function
// - Latch which axis raised the first interrupt since reset or clear.
// - Sign flags hold interrupt polarity, 0 positive, 1 negative.
// - On each interrupt, signs refresh; disabled axes read 0.
// - Whole interrupt function disabled clears every sign flag.
// - Toggling one axis leaves its sign until the next interrupt.
// - First-axis flags clear only at power-on or soft reset; sign flags also clear with the interrupt function off.
// - Status bit shows nonvolatile write in progress.
// - While that write runs, every register write is dropped.
// - Temperature byte is two's complement, 0.5 K per step.
// - Each axis holds a 14-bit two's complement value.
// - Short result option forces two lowest acceleration bits to 0.
// - Acceleration registers refresh each update period from filter.
// - Low byte read copies high byte into shadow for later read.
// - Without low read, shadowed high read is stale; disable to avoid.
// - Low byte bit 0 carries the axis new-data flag.
// - New-data flag sets on update, clears on reading either byte.
// - New-data interrupt rises once per period after all four channels.
// - Very first access being low read leaves paired high at 00.
// - Read-only three-bit part identifier.
// - Chip select high picks I2C, low picks four-wire SPI.
// - Writing B6 to soft reset register acts as power-on reset.
// - Interrupt clear works only on a latched, generated interrupt.
module asdr_readout #(
	parameter logic [2:0] PART_ID     = 3'h5,  // Arbitrary code
	parameter int         CONV_CYCLES = asdr_pkg::CONV_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        CE,
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	input  wire logic        SAMPLE_VALID,
	input  wire logic [1:0]  SAMPLE_CHAN,
	input  wire logic [13:0] SAMPLE_DATA,
	input  wire logic        INT_EVENT,
	input  wire logic [2:0]  EVENT_AXIS,
	input  wire logic [2:0]  EVENT_SIGN,
	input  wire logic        INT_FUNC_EN,
	input  wire logic        INT_LATCH_EN,
	input  wire logic [2:0]  AXIS_EN,
	input  wire logic        NVM_WRITE_BUSY,
	input  wire logic        CHIP_SELECT_N,
	input  wire logic        SERIAL_CLK,
	output logic             INT_OUT,
	output logic             I2C_MODE,
	output logic             NVM_RELOAD
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0]                    rdata;
		logic [2:0][asdr_pkg::ACC_W-1:0] acc;
		logic [7:0]                    temp;
		logic [2:0][7:0]               shadow;
		logic [2:0]                    new_flag;
		logic                          seen_txn;
		logic [2:0]                    first;
		logic                          first_taken;
		logic [2:0]                    sign;
		logic                          int_latched;
		logic                          int_pulse;
		logic                          ndi;
		logic                          int_out;
		logic                          short_sel;
		logic                          shadow_dis;
		logic                          ndi_en;
		logic                          quiet_viol;
		asdr_pkg::asdr_qw_t            qw;
		logic [asdr_pkg::QW_W-1:0]     qw_cnt;
		logic                          link_prev;
		logic                          soft_pulse;
		logic                          i2c_mode;
	} asdr_st_t;

	// Chip select idles high, so I2C is the safe reset choice
	localparam asdr_st_t RST_ST = '{qw: asdr_pkg::QW_IDLE,
		i2c_mode: 1'b1, link_prev: 1'b1, default: '0};
	localparam logic [asdr_pkg::QW_W-1:0] QW_LAST =
		asdr_pkg::QW_W'(CONV_CYCLES - 1);

	asdr_st_t   st;
	asdr_st_t   next_st;
	logic       cs_s;
	logic       link_s;
	logic [1:0] rd_axis;
	logic       link_rise;
	logic       soft_wr;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [1:0] axis_sel(input logic [7:0] a);
		logic [1:0] r;
		r = asdr_pkg::AXIS_NONE;
		if (a >= asdr_pkg::REG_X_LO && a <= asdr_pkg::REG_Z_HI)
			r = 2'((a - asdr_pkg::REG_X_LO) >> 1);
		return r;
	endfunction

	function automatic logic [13:0] trim(input logic [13:0] v,
		input logic short_sel);
		logic [13:0] r;
		r = v;
		if (short_sel)
			r[asdr_pkg::SHORT_DROP-1:0] = '0;
		return r;
	endfunction

	function automatic logic [7:0] hi_byte(input logic [13:0] v,
		input logic short_sel);
		logic [13:0] t;
		t = trim(v, short_sel);
		return t[13:asdr_pkg::LO_ACC_BITS];
	endfunction

	function automatic logic [7:0] lo_byte(input logic [13:0] v,
		input logic short_sel, input logic nf);
		logic [13:0] t;
		logic [7:0]  r;
		t = trim(v, short_sel);
		r = '0;
		r[7:asdr_pkg::LO_DATA_LSB] = t[asdr_pkg::LO_ACC_BITS-1:0];
		r[asdr_pkg::NEW_FLAG_POS]  = nf;
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	asdr_sync #(
		.W (2)
	) u_sync (
		.CLK    (CLK),
		.ARST_N (ARST_N),
		.CE     (CE),
		.D      ({CHIP_SELECT_N, SERIAL_CLK}),
		.Q      ({cs_s, link_s})
	);

	assign rd_axis   = axis_sel(ADDR);
	assign link_rise = link_s && !st.link_prev;
	assign soft_wr   = WR && !NVM_WRITE_BUSY &&
		ADDR == asdr_pkg::REG_SOFT_RST &&
		WDATA == asdr_pkg::SOFT_RESET_CODE;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_st           = st;
		next_st.int_pulse = 1'b0;
		next_st.soft_pulse = 1'b0;
		next_st.link_prev = link_s;
		next_st.i2c_mode  = cs_s;
		next_st.rdata     = '0;
		if (RD || WR)
			next_st.seen_txn = 1'b1;

		// Register reads: data appear in the next cycle only
		if (RD)
		begin
			case (ADDR)
			asdr_pkg::REG_ID:
				next_st.rdata = {5'h00, PART_ID};
			asdr_pkg::REG_X_LO, asdr_pkg::REG_Y_LO, asdr_pkg::REG_Z_LO:
				next_st.rdata = lo_byte(st.acc[rd_axis], st.short_sel,
					st.new_flag[rd_axis]);
			asdr_pkg::REG_X_HI, asdr_pkg::REG_Y_HI, asdr_pkg::REG_Z_HI:
				next_st.rdata = st.shadow_dis ?
					hi_byte(st.acc[rd_axis], st.short_sel) :
					st.shadow[rd_axis];
			asdr_pkg::REG_TEMP:
				next_st.rdata = st.temp;
			asdr_pkg::REG_STAT:
				next_st.rdata = {NVM_WRITE_BUSY, st.first, st.sign,
					st.int_latched};
			asdr_pkg::REG_STAT2:
				next_st.rdata = {6'h00, st.ndi, st.quiet_viol};
			asdr_pkg::REG_CTRL:
				next_st.rdata = {5'h00, st.ndi_en, st.shadow_dis,
					st.short_sel};
			default:
				next_st.rdata = '0;
			endcase
			if (rd_axis != asdr_pkg::AXIS_NONE)
			begin
				next_st.new_flag[rd_axis] = 1'b0;
				next_st.ndi = 1'b0;
				// First access ever leaves the shadow at its reset value
				if (!ADDR[0] && !st.shadow_dis && st.seen_txn)
					next_st.shadow[rd_axis] =
						hi_byte(st.acc[rd_axis], st.short_sel);
			end
		end

		// Register writes, all dropped during a nonvolatile write
		if (WR && !NVM_WRITE_BUSY)
		begin
			case (ADDR)
			asdr_pkg::REG_CTRL:
			begin
				next_st.short_sel  = WDATA[asdr_pkg::CTRL_SHORT];
				next_st.shadow_dis = WDATA[asdr_pkg::CTRL_SHADOW_DIS];
				next_st.ndi_en     = WDATA[asdr_pkg::CTRL_NDI_EN];
				if (WDATA[asdr_pkg::CTRL_RESET_INT] && st.int_latched)
				begin
					next_st.int_latched = 1'b0;
					next_st.first_taken = 1'b0;
				end
			end
			asdr_pkg::REG_STAT2:
				if (WDATA[asdr_pkg::STAT2_QUIET_VIOL])
					next_st.quiet_viol = 1'b0;
			default:
				next_st.quiet_viol = next_st.quiet_viol;
			endcase
		end

		// Conversion results; a whole axis word lands in one cycle
		if (SAMPLE_VALID)
		begin
			if (SAMPLE_CHAN == asdr_pkg::CHAN_TEMP)
			begin
				next_st.temp = SAMPLE_DATA[asdr_pkg::TEMP_W-1:0];
				next_st.ndi  = 1'b0;
			end
			else
			begin
				next_st.acc[SAMPLE_CHAN - asdr_pkg::CHAN_X] =
					SAMPLE_DATA;
				next_st.new_flag[SAMPLE_CHAN - asdr_pkg::CHAN_X] =
					1'b1;
			end
			// Last channel of the period closes the cycle of four
			if (SAMPLE_CHAN == asdr_pkg::CHAN_Z)
			begin
				if (st.ndi_en)
					next_st.ndi = 1'b1;
				next_st.qw     = asdr_pkg::QW_OPEN;
				next_st.qw_cnt = '0;
			end
		end

		// Interrupt status; events win over a clear in the same cycle
		if (!INT_FUNC_EN)
			next_st.sign = 3'h0;
		else if (INT_EVENT)
		begin
			next_st.sign      = AXIS_EN & EVENT_SIGN;
			next_st.int_pulse = 1'b1;
			if (!st.first_taken || !next_st.first_taken)
			begin
				next_st.first       = EVENT_AXIS;
				next_st.first_taken = 1'b1;
			end
			if (INT_LATCH_EN)
				next_st.int_latched = 1'b1;
		end
		if (!INT_LATCH_EN)
			next_st.int_latched = 1'b0;

		// Link activity watch after the quiet-read window closes
		case (st.qw)
		asdr_pkg::QW_IDLE:
			next_st.qw = next_st.qw;
		asdr_pkg::QW_OPEN:
			if (!(SAMPLE_VALID && SAMPLE_CHAN == asdr_pkg::CHAN_Z))
			begin
				next_st.qw_cnt = st.qw_cnt + 1'b1;
				if (st.qw_cnt == QW_LAST)
					next_st.qw = asdr_pkg::QW_SHUT;
			end
		asdr_pkg::QW_SHUT:
			if (link_rise)
				next_st.quiet_viol = 1'b1;
		default:
			next_st.qw = asdr_pkg::QW_IDLE;
		endcase

		next_st.int_out = next_st.int_latched || next_st.int_pulse ||
			next_st.ndi;

		// Soft reset drops everything, then asks for the image reload
		if (soft_wr)
		begin
			next_st            = RST_ST;
			next_st.soft_pulse = 1'b1;
			next_st.i2c_mode   = cs_s;
			next_st.link_prev  = link_s;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			st <= RST_ST;
		else if (CE)
			st <= next_st;
	end

	assign RDATA      = st.rdata;
	assign INT_OUT    = st.int_out;
	assign I2C_MODE   = st.i2c_mode;
	assign NVM_RELOAD = st.soft_pulse;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	logic [7:0] x_hi_now;
	assign x_hi_now = hi_byte(st.acc[0], st.short_sel);

	property p_first_stable;
		(CE && st.first_taken && !soft_wr) |=> $stable(st.first);
	endproperty
	a_first_stable: assert property (p_first_stable)
		else $error("first-axis flags changed while latched");

	property p_sign_off;
		(CE && !INT_FUNC_EN) |=> st.sign == 3'h0;
	endproperty
	a_sign_off: assert property (p_sign_off)
		else $error("sign flags not cleared with function off");

	property p_sign_refresh;
		(CE && INT_FUNC_EN && INT_EVENT && !soft_wr) |=>
			st.sign == $past(AXIS_EN & EVENT_SIGN);
	endproperty
	a_sign_refresh: assert property (p_sign_refresh)
		else $error("sign flags not refreshed on interrupt");

	property p_sign_hold;
		(CE && INT_FUNC_EN && !INT_EVENT && !soft_wr) |=>
			$stable(st.sign);
	endproperty
	a_sign_hold: assert property (p_sign_hold)
		else $error("sign flags moved without interrupt");

	property p_busy_drop;
		(CE && WR && NVM_WRITE_BUSY && ADDR == asdr_pkg::REG_CTRL) |=>
			$stable({st.short_sel, st.shadow_dis, st.ndi_en});
	endproperty
	a_busy_drop: assert property (p_busy_drop)
		else $error("write taken during nonvolatile write");

	property p_new_set;
		(CE && SAMPLE_VALID && SAMPLE_CHAN == asdr_pkg::CHAN_X &&
			!soft_wr) |=> st.new_flag[0];
	endproperty
	a_new_set: assert property (p_new_set)
		else $error("new-data flag not set on update");

	property p_id_read;
		(CE && RD && ADDR == asdr_pkg::REG_ID) |=>
			RDATA == {5'h00, PART_ID};
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("identifier read wrong");

	property p_ndi;
		(CE && SAMPLE_VALID && SAMPLE_CHAN == asdr_pkg::CHAN_Z &&
			st.ndi_en && !soft_wr) |=> INT_OUT;
	endproperty
	a_ndi: assert property (p_ndi)
		else $error("new-data interrupt missing");

	property p_short;
		(CE && RD && ADDR == asdr_pkg::REG_X_LO && st.short_sel) |=>
			RDATA[asdr_pkg::LO_DATA_LSB+1:asdr_pkg::LO_DATA_LSB] == 2'h0;
	endproperty
	a_short: assert property (p_short)
		else $error("short result bits not forced to zero");

	sequence s_lo_then_hi;
		(CE && RD && ADDR == asdr_pkg::REG_X_LO && !st.shadow_dis &&
			st.seen_txn && !WR) ##1
		(CE && RD && ADDR == asdr_pkg::REG_X_HI && !st.shadow_dis);
	endsequence

	property p_shadow;
		s_lo_then_hi |=> RDATA == $past(x_hi_now, 2);
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("shadowed high byte wrong");

	c_ndi: cover property (CE && st.ndi_en && SAMPLE_VALID &&
		SAMPLE_CHAN == asdr_pkg::CHAN_Z);
	c_soft: cover property (CE && soft_wr);
	c_shadow: cover property (s_lo_then_hi);
	c_quiet: cover property (CE && st.qw == asdr_pkg::QW_SHUT &&
		link_rise);
endmodule

// *** test/asdr_host_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------------
module asdr_host_model (
	input  wire logic spi_sel,
	output logic      serial_clk,
	output logic      chip_select_n
);
	// Clock idles high, so select changes never see it move
	initial serial_clk = 1'b1;
	assign chip_select_n = ~spi_sel;
	// Edges only within a burst, then the clock stands still
	task automatic burst(input int n);
		repeat (n)
		begin
			#62.5 serial_clk = 1'b0;
			#62.5 serial_clk = 1'b1;
		end
	endtask
endmodule

// *** test/accel_status_data_readout_bench.sv ***
`timescale 1ns/100ps
module accel_status_data_readout_bench;
	// Arbitrary code
	localparam logic [2:0] PID  = 3'h2;
	localparam int         CONV = 40;
	logic        clk, arst_n, ce, wr_stb, rd_stb, s_valid, int_event;
	logic        func_en, latch_en, nvm_busy, spi_sel, sclk, csn;
	logic        int_out, i2c_mode, nvm_reload;
	logic [7:0]  addr, wdata, rdata;
	logic [1:0]  s_chan;
	logic [13:0] s_data;
	logic [2:0]  ev_axis, ev_sign, axis_en;
	int          fails, checks;

	asdr_readout #(.PART_ID(PID), .CONV_CYCLES(CONV)) dut (
		.CLK(clk), .ARST_N(arst_n), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata),
		.SAMPLE_VALID(s_valid), .SAMPLE_CHAN(s_chan),
		.SAMPLE_DATA(s_data), .INT_EVENT(int_event),
		.EVENT_AXIS(ev_axis), .EVENT_SIGN(ev_sign),
		.INT_FUNC_EN(func_en), .INT_LATCH_EN(latch_en),
		.AXIS_EN(axis_en), .NVM_WRITE_BUSY(nvm_busy),
		.CHIP_SELECT_N(csn), .SERIAL_CLK(sclk), .INT_OUT(int_out),
		.I2C_MODE(i2c_mode), .NVM_RELOAD(nvm_reload)
	);
	asdr_host_model host (
		.spi_sel(spi_sel), .serial_clk(sclk), .chip_select_n(csn)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask
	// Low then high byte with no gap, as the pairing wants
	task automatic rd_pair(input logic [7:0] a, input logic [7:0] el,
		input logic [7:0] eh);
		logic [7:0] d;
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		addr <= a + 8'h01;
		#1;
		d = rdata;
		chk("pair lo", d, el);
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk("pair hi", rdata, eh);
	endtask
	task automatic samp(input logic [1:0] c, input logic [13:0] v);
		@(posedge clk);
		s_chan  <= c;
		s_data  <= v;
		s_valid <= 1'b1;
		@(posedge clk);
		s_valid <= 1'b0;
		#1;
	endtask
	task automatic event_pulse(input logic [2:0] a, input logic [2:0] s);
		@(posedge clk);
		ev_axis   <= a;
		ev_sign   <= s;
		int_event <= 1'b1;
		@(posedge clk);
		int_event <= 1'b0;
		#1;
	endtask
	// Pulses are short, so look at three cycles in a row
	task automatic reload_seen(output logic s);
		s = 1'b0;
		repeat (3)
		begin
			s = s | (nvm_reload === 1'b1);
			@(posedge clk);
			#1;
		end
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_first;
		chk("int_out", {7'h00, int_out}, 8'h00);
		samp(asdr_pkg::CHAN_X, 14'h2000);
		chk("i2c_mode", {7'h00, i2c_mode}, 8'h01);
		rd_chk(asdr_pkg::REG_X_LO, 8'h01);
		rd_chk(asdr_pkg::REG_X_HI, 8'h00);
		rd_chk(asdr_pkg::REG_X_LO, 8'h00);
		rd_chk(asdr_pkg::REG_X_HI, 8'h80);
		rd_chk(8'h01, 8'h00);
		rd_chk(asdr_pkg::REG_ID, {5'h00, PID});
	endtask
	task automatic t_frame;
		wr_reg(asdr_pkg::REG_CTRL, 8'h04);
		samp(asdr_pkg::CHAN_TEMP, 14'h0080);
		samp(asdr_pkg::CHAN_X, 14'h1FFF);
		samp(2'h2, 14'h0001);
		chk("ndi early", {7'h00, int_out}, 8'h00);
		samp(asdr_pkg::CHAN_Z, 14'h0000);
		chk("ndi", {7'h00, int_out}, 8'h01);
		rd_chk(asdr_pkg::REG_TEMP, 8'h80);
		rd_pair(asdr_pkg::REG_X_LO, 8'hFD, 8'h7F);
		rd_pair(asdr_pkg::REG_Y_LO, 8'h05, 8'h00);
		rd_chk(asdr_pkg::REG_Z_HI, 8'h00);
		rd_chk(asdr_pkg::REG_Z_LO, 8'h00);
	endtask
	task automatic t_shadow;
		rd_chk(asdr_pkg::REG_X_LO, 8'hFC);
		samp(asdr_pkg::CHAN_X, 14'h0000);
		rd_chk(asdr_pkg::REG_X_HI, 8'h7F);
		wr_reg(asdr_pkg::REG_CTRL, 8'h06);
		rd_chk(asdr_pkg::REG_X_HI, 8'h00);
		wr_reg(asdr_pkg::REG_CTRL, 8'h07);
		samp(asdr_pkg::CHAN_X, 14'h1FFF);
		rd_chk(asdr_pkg::REG_X_LO, 8'hF1);
		rd_chk(asdr_pkg::REG_X_HI, 8'h7F);
	endtask
	task automatic t_events;
		logic s;
		func_en <= 1'b1;
		axis_en <= 3'b101;
		event_pulse(3'b010, 3'b111);
		chk("int latched", {7'h00, int_out}, 8'h01);
		rd_chk(asdr_pkg::REG_STAT, 8'h2B);
		event_pulse(3'b001, 3'b000);
		rd_chk(asdr_pkg::REG_STAT, 8'h21);
		axis_en <= 3'b111;
		ev_sign <= 3'b111;
		rd_chk(asdr_pkg::REG_STAT, 8'h21);
		wr_reg(asdr_pkg::REG_CTRL, 8'h0C);
		rd_chk(asdr_pkg::REG_STAT, 8'h20);
		event_pulse(3'b100, 3'b111);
		rd_chk(asdr_pkg::REG_STAT, 8'h4F);
		func_en <= 1'b0;
		@(posedge clk);
		#1;
		rd_chk(asdr_pkg::REG_STAT, 8'h41);
		wr_reg(asdr_pkg::REG_SOFT_RST, asdr_pkg::SOFT_RESET_CODE);
		reload_seen(s);
		chk("reload", {7'h00, s}, 8'h01);
		rd_chk(asdr_pkg::REG_STAT, 8'h00);
	endtask
	task automatic t_nvm;
		logic s;
		nvm_busy <= 1'b1;
		rd_chk(asdr_pkg::REG_STAT, 8'h80);
		wr_reg(asdr_pkg::REG_SOFT_RST, asdr_pkg::SOFT_RESET_CODE);
		reload_seen(s);
		chk("busy reload", {7'h00, s}, 8'h00);
		wr_reg(asdr_pkg::REG_CTRL, 8'h07);
		rd_chk(asdr_pkg::REG_CTRL, 8'h00);
		nvm_busy <= 1'b0;
	endtask
	// Non-latched mode, then a frozen clock enable
	task automatic t_pulse;
		func_en  <= 1'b1;
		latch_en <= 1'b0;
		event_pulse(3'b001, 3'b001);
		chk("pulse", {7'h00, int_out}, 8'h01);
		@(posedge clk);
		#1;
		chk("pulse end", {7'h00, int_out}, 8'h00);
		rd_chk(asdr_pkg::REG_STAT, 8'h12);
		latch_en <= 1'b1;
		func_en  <= 1'b0;
		ce       <= 1'b0;
		samp(asdr_pkg::CHAN_TEMP, 14'h0011);
		ce <= 1'b1;
		rd_chk(asdr_pkg::REG_TEMP, 8'h00);
	endtask
	task automatic t_mode(input logic sel);
		int n;
		@(posedge clk);
		spi_sel <= sel;
		n = 0;
		while (i2c_mode !== ~sel && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("i2c_mode", {7'h00, i2c_mode}, {7'h00, ~sel});
		if (n >= 8)
			complete_run();
	endtask
	task automatic t_link;
		wr_reg(asdr_pkg::REG_CTRL, 8'h04);
		samp(asdr_pkg::CHAN_Z, 14'h0000);
		host.burst(2);
		rd_chk(asdr_pkg::REG_STAT2, 8'h02);
		repeat (CONV) @(posedge clk);
		host.burst(1);
		repeat (4) @(posedge clk);
		rd_chk(asdr_pkg::REG_STAT2, 8'h03);
		wr_reg(asdr_pkg::REG_STAT2, 8'h01);
		rd_chk(asdr_pkg::REG_STAT2, 8'h02);
	endtask

	initial
	begin
		#400000;
		fails++;
		complete_run();
	end
	initial
	begin
		fails     = 0;
		checks    = 0;
		arst_n    = 1'b0;
		ce        = 1'b1;
		wr_stb    = 1'b0;
		rd_stb    = 1'b0;
		addr      = 8'h00;
		wdata     = 8'h00;
		s_valid   = 1'b0;
		s_chan    = 2'h0;
		s_data    = 14'h0000;
		int_event = 1'b0;
		ev_axis   = 3'h0;
		ev_sign   = 3'h0;
		func_en   = 1'b0;
		latch_en  = 1'b1;
		axis_en   = 3'h0;
		nvm_busy  = 1'b0;
		spi_sel   = 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_first();
		t_frame();
		t_shadow();
		t_events();
		t_nvm();
		t_pulse();
		t_mode(1'b1);
		t_mode(1'b0);
		t_link();
		complete_run();
	end
endmodule
